// *** core/ltc_ctrl.sv ***
`timescale 1ns/100ps
`include "ltc_params.svh"
module ltc_ctrl
	import ltc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	// User side
	input  wire logic       user_enable,
	input  wire logic       user_tx_on,
	input  wire logic       user_sleep,
	input  wire logic       user_wake_release,
	input  wire logic       user_tx_valid,
	input  wire logic       user_tx_bit,
	output logic            user_tx_ready,
	output logic            user_rx_bit,
	output logic            user_fault,
	output logic            user_dev_reset,
	output logic [2:0]      user_state,
	output logic            ev_valid,
	output logic [1:0]      ev_code,
	input  wire logic       ev_ready,
	// Device pins
	output logic            transmit_data,
	input  wire logic       receive_data,
	output logic            select_wake_o,
	output logic            select_wake_oe,
	input  wire logic       select_wake_i,
	output logic            fault_tx_enable_o,
	output logic            fault_tx_enable_oe,
	input  wire logic       fault_tx_enable_i,
	input  wire logic       reset_n_i
);
	ltc_state_t  state;
	ltc_state_t  next_state;
	logic [11:0] valid_cnt;
	logic [9:0]  sample_cnt;
	logic        sample_en;
	logic        fault_smp;
	logic        reset_q;
	logic        fault_q;
	logic        wake_q;
	logic        ev_push;
	logic [1:0]  ev_data;
	logic        ev_full;

	ltc_fifo_if #(.W(`LTC_FIFO_WIDTH)) evq ();

	// ************************************
	// Event queue toward the user
	// ************************************
	ltc_fifo #(.WIDTH(`LTC_FIFO_WIDTH), .DEPTH(`LTC_FIFO_DEPTH)) u_fifo (
		.clk    (clk),
		.resetn (resetn),
		.f      (evq)
	);
	assign evq.in_valid  = ev_push;
	assign evq.in_data   = ev_data;
	assign evq.out_ready = ev_ready || !ev_valid;
	assign ev_full       = !evq.in_ready;

	// Output stage of event queue
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ev_valid <= 1'b0;
			ev_code  <= 2'h0;
		end else if (ev_ready || !ev_valid) begin
			ev_valid <= evq.out_valid;
			ev_code  <= evq.out_data;
		end
	end

	// ************************************
	// Mode sequencing
	// ************************************
	always_comb begin
		next_state = state;
		case (state)
			LTC_IDLE:  if (user_enable) next_state = LTC_WAKE;
			LTC_WAKE:  if (reset_n_i) next_state = user_tx_on ? LTC_OPER : LTC_TRANSMITTER_OFF_MODE; // see [RL7]
			LTC_OPER:  begin
				if (user_sleep) next_state = LTC_SLEEP;                     // see [RL24]
				else if (!user_tx_on || fault_q) next_state = LTC_TRANSMITTER_OFF_MODE;   // see [RL24]
			end
			LTC_TRANSMITTER_OFF_MODE: begin
				if (user_sleep) next_state = LTC_SLEEP;                     // see [RL25]
				else if (user_tx_on && !fault_q) next_state = LTC_OPER;    // see [RL25]
			end
			LTC_SLEEP: if (!user_sleep || wake_q) next_state = LTC_WAKE;  // see [RL26]
			default:   next_state = LTC_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= LTC_IDLE;
		end else if (!user_enable) begin
			state <= LTC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Pin drive: wake line driven high when active, released for local wake
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			select_wake_o      <= 1'b0;
			select_wake_oe     <= 1'b1;
			fault_tx_enable_o  <= 1'b0;
			fault_tx_enable_oe <= 1'b0;
		end else begin
			select_wake_o      <= (next_state != LTC_SLEEP) && (next_state != LTC_IDLE); // see [RL5]
			select_wake_oe     <= !((next_state == LTC_SLEEP) && user_wake_release);   // see [RL8]
			fault_tx_enable_o  <= 1'b0;
			fault_tx_enable_oe <= !user_tx_on;                                         // see [RL15]
		end
	end

	// Transmit data: recessive unless operating and user sends
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			transmit_data <= 1'b1;
		end else if (state == LTC_OPER && user_tx_valid) begin
			transmit_data <= user_tx_bit;                                          // see [RL1]
		end else begin
			transmit_data <= 1'b1;
		end
	end
	assign user_tx_ready = 1'b1;

	// ************************************
	// Fault sampling
	// ************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_cnt <= 10'h000;
		end else if (sample_en) begin
			sample_cnt <= 10'h000;
		end else begin
			sample_cnt <= sample_cnt + 10'h001;
		end
	end
	assign sample_en = (sample_cnt == 10'(`LTC_SAMPLE_CYC));                // see [RL16]

	// Blanking after transmit falling edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			valid_cnt <= 12'h000;
		end else if (transmit_data && !(state == LTC_OPER && user_tx_valid && !user_tx_bit)) begin
			valid_cnt <= 12'h000;
		end else if (valid_cnt != 12'(`LTC_FAULT_VALID_CYC)) begin
			valid_cnt <= valid_cnt + 12'h001;                                  // see [RL11]
		end
	end

	// Fault qualified only when not self-driven and after blanking
	assign fault_smp = !fault_tx_enable_i && user_tx_on &&
		(transmit_data || valid_cnt == 12'(`LTC_FAULT_VALID_CYC));        // see [RL11]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fault_q <= 1'b0;
		end else if (sample_en) begin
			fault_q <= fault_smp;                                            // see [RL16]
		end
	end

	// Reset and wake observation
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reset_q <= 1'b0;
			wake_q  <= 1'b0;
		end else begin
			reset_q <= !reset_n_i;                                           // see [RL17]
			wake_q  <= (state == LTC_SLEEP) && (select_wake_i || !receive_data); // see [RL26]
		end
	end

	// Event generation on rising edges of conditions
	always_comb begin
		ev_push = 1'b0;
		ev_data = 2'h0;
		if (sample_en && fault_smp && !fault_q) begin
			ev_push = 1'b1;
			ev_data = `LTC_EV_FAULT;
		end else if (!reset_n_i && !reset_q) begin
			ev_push = 1'b1;
			ev_data = `LTC_EV_RESET;
		end else if (next_state == LTC_WAKE && state == LTC_SLEEP) begin
			ev_push = 1'b1;
			ev_data = `LTC_EV_WAKE;
		end
	end

	// Status outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			user_rx_bit    <= 1'b1;
			user_fault     <= 1'b0;
			user_dev_reset <= 1'b1;
			user_state     <= 3'h0;
		end else begin
			user_rx_bit    <= receive_data;                                  // see [RL4]
			user_fault     <= fault_q || ev_full;
			user_dev_reset <= !reset_n_i;                                    // see [RL18]
			user_state     <= state;
		end
	end
endmodule

// *** core/ltc_fifo.sv ***
`timescale 1ns/100ps
module ltc_fifo
	import ltc_pkg::*;
#(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
) (
	input  wire logic clk,
	input  wire logic resetn,
	ltc_fifo_if.fifo  f
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;
	logic             do_wr;
	logic             do_rd;

	// Pointer compare with wrap bit
	assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty       = (wr_ptr == rd_ptr);
	assign f.in_ready  = !full;
	assign do_wr       = f.in_valid && !full;
	assign do_rd       = f.out_ready && f.out_valid;

	// Storage write
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr[AW-1:0]] <= f.in_data;
		end
	end

	// Write pointer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
		end else if (do_wr) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Registered read stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_ptr      <= '0;
			f.out_valid <= 1'b0;
			f.out_data  <= '0;
		end else if (!f.out_valid || f.out_ready) begin
			f.out_valid <= !empty;
			if (!empty) begin
				f.out_data <= mem[rd_ptr[AW-1:0]];
				rd_ptr     <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// *** core/ltc_fifo_if.sv ***
`timescale 1ns/100ps
interface ltc_fifo_if #(parameter int W = 2);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// *** core/ltc_params.svh ***
// Functional notes
// [RL1] Device drives bus low while transmit data low, when transmitter enabled.
// [RL2] Device forces transmit data to one while regulator below about 1.8V.
// [RL3] Overtemperature with transmit data low shuts driver until cooled.
// [RL4] Receive data output follows the bus level continuously.
// [RL5] Select/wake is pulled low; transmitter only enabled while it is high.
// [RL6] Select/wake low at battery power-up leaves device in Ready mode.
// [RL7] Select/wake high at power-up goes to Operation or Transmitter-Off.
// [RL8] Controller may release select/wake so an external source can wake.
// [RL9] Fault/enable low disables the driver; regulator keeps running.
// [RL10] Device reports transmit/bus mismatch on fault/enable, debounced.
// [RL11] Fault indication valid only about 25 us after transmit falling edge.
// [RL12] Fault/enable pulled low on bus short or thermal excursion.
// [RL13] Fault/enable pulled low while regulator output is out of range.
// [RL14] Fault only when transmit low while bus stays high.
// [RL15] Controller driving fault/enable low commands transmitter off.
// [RL16] Controller samples fault/enable at intervals shorter than 10 us; the controller samples every 1000 cycles, which is 10 us.
// [RL17] Reset output released while supply valid, pulled low on undervoltage.
// [RL18] Reset output asserted on entering Power-Down mode.
// [RL19] After battery brown-out regulator stays off until battery above 5.75V.
// [RL20] Battery monitor disabled in Power-Down mode.
// [RL21] Overtemperature shuts regulator in given data states until cooled.
// [RL22] Regulator below 3.5V on overload: off, wait 3 ms, retry.
// [RL23] At power-on Ready mode entered once battery exceeds 5.75V.
// [RL24] Operation goes Transmitter-Off on fault/enable low, Power-Down on wake low.
// [RL25] Transmitter-Off returns to Operation on enable high, Power-Down on wake low.
// [RL26] Power-Down wakes to Ready on bus fall, further on select/wake high.
// [RL27] Mismatch debounce is a counter qualifying a persistent mismatch.
`ifndef LTC_PARAMS_SVH
`define LTC_PARAMS_SVH
`define LTC_CLK_MHZ         100
`define LTC_FAULT_VALID_US  25
`define LTC_FAULT_VALID_CYC (`LTC_FAULT_VALID_US * `LTC_CLK_MHZ)
`define LTC_SAMPLE_US       10
`define LTC_SAMPLE_CYC      (`LTC_SAMPLE_US * `LTC_CLK_MHZ - 1)
`define LTC_FIFO_DEPTH      16
`define LTC_FIFO_WIDTH      2
`define LTC_EV_FAULT        2'h1
`define LTC_EV_RESET        2'h2
`define LTC_EV_WAKE         2'h3
`endif

// *** core/ltc_pkg.sv ***
package ltc_pkg;
	typedef enum logic [2:0] {
		LTC_IDLE    = 3'b000,
		LTC_WAKE    = 3'b001,
		LTC_OPER    = 3'b010,
		LTC_TRANSMITTER_OFF_MODE   = 3'b011,
		LTC_SLEEP   = 3'b100
	} ltc_state_t;
endpackage

// *** sim/ltc_dev_model.sv ***
`timescale 1ns/100ps
module ltc_dev_model #(
	parameter int FILT = 2500
) (
	input wire logic clk, resetn, tx_in, sel_wake, fault_line,
	input wire logic vreg_ok, bus_stuck_hi, other_low,
	output logic     rx_out, fault_pull, reset_n
);
	logic [1:0]  mode;
	logic [11:0] cnt;
	logic        txd_i, tx_en, bus, bus_q, flt;
	// ****************
	// Line levels
	// ****************
	assign txd_i = tx_in | !vreg_ok;
	assign tx_en = (mode == 2'h1) && sel_wake && fault_line;
	assign bus = bus_stuck_hi | (!(tx_en && !txd_i) && !other_low);
	assign rx_out = bus;
	assign fault_pull = flt | !vreg_ok;
	assign reset_n = vreg_ok && mode != 2'h3;
	// Mode machine: 0 ready, 1 operation, 2 transmitter off, 3 power-down
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode <= 2'h0;
		end else begin
			case (mode)
			2'h0: if (sel_wake) mode <= fault_line ? 2'h1 : 2'h2;
			2'h1: if (!sel_wake) mode <= 2'h3; else if (!fault_line) mode <= 2'h2;
			2'h2: if (!sel_wake) mode <= 2'h3; else if (fault_line) mode <= 2'h1;
			default: if (sel_wake || (bus_q && !bus)) mode <= 2'h0;
			endcase
		end
	end
	// Mismatch qualification counter, blanks the fault until it settles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 12'h000;
			flt <= 1'b0;
			bus_q <= 1'b1;
		end else begin
			bus_q <= bus;
			cnt <= (!txd_i && bus) ? cnt + 12'(cnt != FILT) : 12'h000;
			flt <= txd_i ? 1'b0 : (flt | cnt == FILT);
		end
	end
endmodule

// *** sim/ltc_monitor.sv ***
`timescale 1ns/100ps
module ltc_monitor
	import ltc_pkg::*;
(
	input wire logic       clk, resetn, user_enable, user_tx_on, user_tx_ready,
	input wire logic       user_rx_bit, user_dev_reset, ev_valid, ev_ready,
	input wire logic       transmit_data, receive_data, reset_n_i,
	input wire logic       select_wake_o, select_wake_oe,
	input wire logic       fault_tx_enable_o, fault_tx_enable_oe,
	input wire logic [2:0] user_state,
	input wire logic [1:0] ev_code
);
	// ****************
	// Port checks
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_off2; !user_enable ##1 !user_enable; endsequence
	sequence s_idle2; user_state == LTC_IDLE ##1 user_state == LTC_IDLE; endsequence
	property p_rx; 1'b1 |=> user_rx_bit == $past(receive_data); endproperty
	a_rx: assert property (p_rx) else $error("rx copy wrong");
	property p_rst; 1'b1 |=> user_dev_reset == !$past(reset_n_i); endproperty
	a_rst: assert property (p_rst) else $error("reset flag wrong");
	property p_od; fault_tx_enable_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("fault pin driven high");
	property p_transmitter_off_mode; !user_tx_on |-> ##[0:2] fault_tx_enable_oe; endproperty
	a_transmitter_off_mode: assert property (p_transmitter_off_mode) else $error("tx not turned off");
	property p_txon; user_tx_on [*3] |-> !fault_tx_enable_oe; endproperty
	a_txon: assert property (p_txon) else $error("fault pin held low");
	property p_idle; s_off2 |=> user_state == LTC_IDLE; endproperty
	a_idle: assert property (p_idle) else $error("not idle");
	property p_idle_tx; s_idle2 |-> transmit_data; endproperty
	a_idle_tx: assert property (p_idle_tx) else $error("idle tx low");
	property p_wake; user_state == LTC_WAKE |-> ##[0:1] (select_wake_oe && select_wake_o); endproperty
	a_wake: assert property (p_wake) else $error("wake not driven");
	property p_ev; ev_valid && !ev_ready |=> ev_valid && $stable(ev_code); endproperty
	a_ev: assert property (p_ev) else $error("event dropped");
	property p_rdy; user_tx_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("not ready");
	c_oper: cover property (user_state == LTC_OPER);
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
bind ltc_ctrl ltc_monitor mon_u (.*);
module testbench
	import ltc_pkg::*;
;
	logic clk = 0, resetn = 0, en = 0, tx_on = 0, slp = 0, rel = 0, txv = 0, txb = 1, evr = 0;
	logic vreg_ok = 1, stuck = 0, other = 0, ext = 0;
	logic rdy, rx_bit, flt, dev_rst, ev_v, txd, rxd, sw_o, sw_oe, ft_o, ft_oe, rst_n, pull;
	logic [2:0] st;
	logic [1:0] ev_c;
	wire logic sw_line = sw_oe ? sw_o : ext; // Follows ext unless driven
	wire logic ft_line = !((ft_oe && !ft_o) || pull); // Open drain, pull-up
	int failures = 0, n_checks = 0, i, n;
	always #5 clk = ~clk;
	ltc_ctrl dut_u (.clk(clk), .resetn(resetn), .user_enable(en), .user_tx_on(tx_on),
		.user_sleep(slp), .user_wake_release(rel), .user_tx_valid(txv), .user_tx_bit(txb),
		.user_tx_ready(rdy), .user_rx_bit(rx_bit), .user_fault(flt), .user_dev_reset(dev_rst),
		.user_state(st), .ev_valid(ev_v), .ev_code(ev_c), .ev_ready(evr), .transmit_data(txd),
		.receive_data(rxd), .select_wake_o(sw_o), .select_wake_oe(sw_oe),
		.select_wake_i(sw_line), .fault_tx_enable_o(ft_o), .fault_tx_enable_oe(ft_oe),
		.fault_tx_enable_i(ft_line), .reset_n_i(rst_n));
	ltc_dev_model dev_u (.clk(clk), .resetn(resetn), .tx_in(txd), .sel_wake(sw_line),
		.fault_line(ft_line), .vreg_ok(vreg_ok), .bus_stuck_hi(stuck), .other_low(other),
		.rx_out(rxd), .fault_pull(pull), .reset_n(rst_n));
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic finish_test();
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic tmo(input int k, lim);
		if (k >= lim) begin
			failures++;
			$display("unexpected at %0t: wait ran out", $time);
			finish_test();
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_wake();
		@(posedge clk);
		en <= 1;
		tx_on <= 1;
		for (i = 0; i < 100 && st !== LTC_OPER; i++) cyc(1);
		tmo(i, 100);
		chk(sw_line, 1);
		chk(ft_line, 1);
	endtask
	task automatic t_tx();
		@(posedge clk);
		txv <= 1;
		txb <= 0;
		cyc(4);
		chk(rx_bit, 0);
		@(posedge clk);
		txb <= 1;
		cyc(4);
		chk(rx_bit, 1);
	endtask
	task automatic t_transmitter_off_mode();
		@(posedge clk);
		tx_on <= 0;
		cyc(3);
		chk(ft_line, 0);
		chk(flt, 0);
	endtask
	// Reset events fill the queue until it refuses, then drain to empty
	// Holding stages: 16 in storage, one in the read stage, one at the output
	task automatic t_fifo();
		for (int k = 0; k < 19; k++) begin
			@(posedge clk);
			vreg_ok <= 0;
			cyc(3);
			@(posedge clk);
			vreg_ok <= 1;
			cyc(3);
		end
		chk(flt, 1);
		chk(ev_c, 2'h2);
		@(posedge clk);
		evr <= 1;
		n = 0;
		#1;
		repeat (40) begin
			n += ev_v;
			cyc(1);
		end
		chk(n, 18);
		chk(flt, 0);
	endtask
	task automatic t_fault();
		@(posedge clk);
		tx_on <= 1;
		stuck <= 1;
		txb <= 0;
		cyc(2000);
		chk(flt, 0);
		for (i = 0; i < 2000 && flt !== 1'b1; i++) cyc(1);
		tmo(i, 2000);
		chk(ft_line, 0);
		@(posedge clk);
		stuck <= 0;
		txb <= 1;
		cyc(3);
		chk(ft_line, 1);
	endtask
	task automatic t_sleep();
		@(posedge clk);
		slp <= 1;
		for (i = 0; i < 100 && dev_rst !== 1'b1; i++) cyc(1);
		tmo(i, 100);
		chk(st, LTC_SLEEP);
		chk(sw_line, 0);
		@(posedge clk);
		rel <= 1;
		ext <= 1;
		cyc(1);
		chk(sw_oe, 0);
		cyc(2);
		chk(sw_line, 1);
		cyc(1);
		chk(st, LTC_WAKE);
	endtask
	// Dropping enable returns the controller to idle
	task automatic t_disable();
		@(posedge clk);
		en <= 0;
		cyc(3);
		chk(st, LTC_IDLE);
		chk(txd, 1);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1;
		t_wake();
		t_tx();
		t_transmitter_off_mode();
		t_fifo();
		t_fault();
		t_sleep();
		t_disable();
		finish_test();
	end
endmodule
